/* File: core/pcr_pkg.sv */
package pcr_pkg;
	// ==========================================
	// register byte addresses
	localparam logic [7:0] ADDR_IRQ_EN = 8'h00;
	localparam logic [7:0] ADDR_IRQ_FLAG = 8'h04;
	localparam logic [7:0] ADDR_CLK_CTRL = 8'h08;
	localparam logic [7:0] ADDR_LOAD_CTRL = 8'h0c;
	localparam logic [7:0] ADDR_SYNC_CTRL = 8'h10;
	localparam logic [7:0] ADDR_LEAD_HIGH = 8'h14;
	localparam logic [7:0] ADDR_LEAD_LOW = 8'h18;
	localparam logic [7:0] ADDR_DUTY_HIGH = 8'h1c;
	localparam logic [7:0] ADDR_CHAN_CTRL = 8'h20;
	// ==========================================
	// field positions
	localparam int FLAG_OFFSET = 3; // offset match
	localparam int FLAG_LEAD = 2; // lead match
	localparam int FLAG_DUTY = 1; // duty match
	localparam int FLAG_PERIOD = 0; // period match
	localparam int CLK_DIV_LSB = 4;
	localparam int CLK_SRC_LSB = 0;
	localparam int LOAD_ARMED_BIT = 7;
	localparam int LOAD_TRIG_BIT = 6;
	localparam int LOAD_SRC_LSB = 0;
	localparam int SYNC_MODE_LSB = 5;
	localparam int CENTER_DIR_BIT = 4;
	localparam int SYNC_SRC_LSB = 0;
	localparam int CHAN_ON_BIT = 7;
	localparam int CHAN_MODE_LSB = 2;
	// ==========================================
	// reset value and implemented-bit masks
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] MASK_IRQ = 8'h0f;
	localparam logic [7:0] MASK_CLK = 8'h73;
	localparam logic [7:0] MASK_LOAD = 8'hc3;
	localparam logic [7:0] MASK_SYNC = 8'h73;
	localparam logic [7:0] MASK_CHAN = 8'h8c;
	// ==========================================
	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ==========================================
	// field encodings
	typedef enum logic [1:0] {
		CS_SYSTEM, CS_FAST_OSC, CS_SLOW_OSC, CS_RESERVED
	} pcr_clk_src_t;
	typedef enum logic [1:0] {
		SM_INDEPENDENT, SM_SLAVE_START, SM_ONE_SHOT, SM_CONT_RESET
	} pcr_sync_mode_t;
	typedef enum logic [1:0] {
		OM_STANDARD, OM_SET_MATCH, OM_TOGGLE_MATCH, OM_CENTER
	} pcr_out_mode_t;
	// configuration handed to the counter logic
	typedef struct packed {
		pcr_sync_mode_t syncMode; // run mode
		logic syncOnDown; // sync match on down count
		pcr_out_mode_t outMode; // output waveform mode
		logic moduleOn; // channel enabled
	} pcr_cfg_t;
endpackage

/* File: core/pcr_pwm_regs.sv */
// Design decisions made here: the register offsets and the AXI4-Lite slave port.
module pcr_pwm_regs (
	input wire logic sys_clk, // system clock, 100 MHz
	input wire logic rst_n, // synchronous reset, low
	input wire logic awvalid, // write address valid
	output logic awready, // write address ready
	input wire logic [7:0] awaddr, // write byte address
	input wire logic wvalid, // write data valid
	output logic wready, // write data ready
	input wire logic [31:0] wdata, // write data
	input wire logic [3:0] wstrb, // write byte strobes
	output logic bvalid, // write answer valid
	input wire logic bready, // write answer ready
	output logic [1:0] bresp, // write answer code
	input wire logic arvalid, // read address valid
	output logic arready, // read address ready
	input wire logic [7:0] araddr, // read byte address
	output logic rvalid, // read data valid
	input wire logic rready, // read data ready
	output logic [31:0] rdata, // read data
	output logic [1:0] rresp, // read answer code
	input wire logic [3:0] matchLevel, // offset,lead,duty,period
	input wire logic periodEnd, // period end pulse
	input wire logic fastOscTick, // fast oscillator tick
	input wire logic slowOscTick, // slow oscillator tick
	input wire logic [3:0] reloadTrigIn, // channel 1..4 loads
	input wire logic [3:0] syncMatchIn, // channel 1..4 sync
	output logic irq, // interrupt request
	output logic pwmTick, // divided pwm clock enable
	output logic reloadEvent, // load pulse to counters
	output logic syncStart, // selected sync event
	output logic [15:0] leadCount, // working lead count
	output logic [7:0] dutyHigh, // working duty high byte
	output pcr_pkg::pcr_cfg_t cfg // run configuration
);
	// ==========================================
	// register state
	logic [7:0] irqEnable; // enable bits
	logic [7:0] irqFlag; // sticky flags
	logic [7:0] clkCtrl; // divider and source
	logic [7:0] loadCtrl; // reload arming
	logic [7:0] syncCtrl; // sync mode and source
	logic [7:0] leadHigh; // pending lead bits 15:8
	logic [7:0] leadLow; // pending lead bits 7:0
	logic [7:0] dutyHighPend; // pending duty bits 15:8
	logic [7:0] chanCtrl; // module on and mode
	logic [3:0] matchPrev; // match level last cycle
	logic trigSeen; // selected trigger caught
	logic [6:0] divCnt; // prescaler count
	logic awHeld; // write address stored
	logic wHeld; // write data stored
	logic [7:0] awAddr; // stored write address
	logic [7:0] wByte; // stored write byte
	logic wLane; // low byte lane strobed
	logic wrDo; // perform stored write
	logic [3:0] matchRise; // rising match edges
	logic srcTick; // chosen source tick
	logic doLoad; // reload happens now
	logic moduleOn; // channel enabled
	logic loadArmed; // arming bit
	logic loadOnTrig; // triggered reload mode
	logic [1:0] loadSrc; // reload trigger source
	// ==========================================
	// decoding helpers
	// address hits an implemented register
	function automatic logic mapped(input logic [7:0] a);
		unique case (a)
			pcr_pkg::ADDR_IRQ_EN, pcr_pkg::ADDR_IRQ_FLAG,
			pcr_pkg::ADDR_CLK_CTRL, pcr_pkg::ADDR_LOAD_CTRL,
			pcr_pkg::ADDR_SYNC_CTRL, pcr_pkg::ADDR_LEAD_HIGH,
			pcr_pkg::ADDR_LEAD_LOW, pcr_pkg::ADDR_DUTY_HIGH,
			pcr_pkg::ADDR_CHAN_CTRL: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	endfunction
	// write enable for one register
	function automatic logic hit(input logic [7:0] a);
		hit = wrDo && wLane && (awAddr == a);
	endfunction
	// last prescaler count: divide by two to the code
	function automatic logic [6:0] divLast(input logic [2:0] c);
		logic [7:0] n;
		n = 8'h01 << c;
		divLast = 7'(n - 8'h01);
	endfunction
	// ==========================================
	// field views
	assign moduleOn = chanCtrl[pcr_pkg::CHAN_ON_BIT];
	assign loadArmed = loadCtrl[pcr_pkg::LOAD_ARMED_BIT];
	assign loadOnTrig = loadCtrl[pcr_pkg::LOAD_TRIG_BIT];
	assign loadSrc = loadCtrl[pcr_pkg::LOAD_SRC_LSB +: 2];
	assign wrDo = awHeld && wHeld && !bvalid;
	assign matchRise = matchLevel & ~matchPrev;
	// reload when armed at a period end, after the trigger when loadOnTrig is set
	assign doLoad = loadArmed && periodEnd
		&& (!loadOnTrig || trigSeen);
	// ==========================================
	// bus write address channel
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			awready <= 1'b0;
			awHeld <= 1'b0;
			awAddr <= 8'h00;
		end else if (awvalid && awready) begin
			awHeld <= 1'b1; // hold until answered
			awAddr <= awaddr;
			awready <= 1'b0;
		end else if (bvalid && bready) begin
			awHeld <= 1'b0;
			awready <= 1'b1;
		end else if (!awHeld) begin
			awready <= 1'b1;
		end
	end
	// bus write data channel
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			wready <= 1'b0;
			wHeld <= 1'b0;
			wByte <= 8'h00;
			wLane <= 1'b0;
		end else if (wvalid && wready) begin
			wHeld <= 1'b1; // only the low lane is stored
			wByte <= wdata[7:0];
			wLane <= wstrb[0];
			wready <= 1'b0;
		end else if (bvalid && bready) begin
			wHeld <= 1'b0;
			wready <= 1'b1;
		end else if (!wHeld) begin
			wready <= 1'b1;
		end
	end
	// write answer once both halves are in
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			bvalid <= 1'b0;
			bresp <= pcr_pkg::RESP_OKAY;
		end else if (wrDo) begin
			bvalid <= 1'b1;
			bresp <= mapped(awAddr) ? pcr_pkg::RESP_OKAY
				: pcr_pkg::RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end
	// ==========================================
	// bus read channel, answer one cycle after address
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= pcr_pkg::RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rresp <= mapped(araddr) ? pcr_pkg::RESP_OKAY
				: pcr_pkg::RESP_SLVERR;
			unique case (araddr)
				pcr_pkg::ADDR_IRQ_EN: rdata <= {24'h0, irqEnable};
				pcr_pkg::ADDR_IRQ_FLAG: rdata <= {24'h0, irqFlag};
				pcr_pkg::ADDR_CLK_CTRL: rdata <= {24'h0, clkCtrl};
				pcr_pkg::ADDR_LOAD_CTRL: rdata <= {24'h0, loadCtrl};
				pcr_pkg::ADDR_SYNC_CTRL: rdata <= {24'h0, syncCtrl};
				pcr_pkg::ADDR_LEAD_HIGH: rdata <= {24'h0, leadHigh};
				pcr_pkg::ADDR_LEAD_LOW: rdata <= {24'h0, leadLow};
				pcr_pkg::ADDR_DUTY_HIGH:
					rdata <= {24'h0, dutyHighPend};
				pcr_pkg::ADDR_CHAN_CTRL: rdata <= {24'h0, chanCtrl};
				default: rdata <= 32'h0000_0000; // unmapped
			endcase
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end else if (!rvalid) begin
			arready <= 1'b1;
		end
	end
	// ==========================================
	// plain control registers, unimplemented bits read 0
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			irqEnable <= pcr_pkg::REG_RESET;
			clkCtrl <= pcr_pkg::REG_RESET;
			syncCtrl <= pcr_pkg::REG_RESET;
			chanCtrl <= pcr_pkg::REG_RESET;
		end else begin
			if (hit(pcr_pkg::ADDR_IRQ_EN))
				irqEnable <= wByte & pcr_pkg::MASK_IRQ;
			if (hit(pcr_pkg::ADDR_CLK_CTRL))
				clkCtrl <= wByte & pcr_pkg::MASK_CLK;
			if (hit(pcr_pkg::ADDR_SYNC_CTRL))
				syncCtrl <= wByte & pcr_pkg::MASK_SYNC;
			if (hit(pcr_pkg::ADDR_CHAN_CTRL))
				chanCtrl <= wByte & pcr_pkg::MASK_CHAN;
		end
	end
	// pending count bytes, written freely by software
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			leadHigh <= pcr_pkg::REG_RESET;
			leadLow <= pcr_pkg::REG_RESET;
			dutyHighPend <= pcr_pkg::REG_RESET;
		end else begin
			if (hit(pcr_pkg::ADDR_LEAD_HIGH))
				leadHigh <= wByte;
			if (hit(pcr_pkg::ADDR_LEAD_LOW))
				leadLow <= wByte;
			if (hit(pcr_pkg::ADDR_DUTY_HIGH))
				dutyHighPend <= wByte;
		end
	end
	// ==========================================
	// match flags: hardware set beats software clear
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			matchPrev <= 4'h0;
			irqFlag <= pcr_pkg::REG_RESET;
		end else begin
			matchPrev <= matchLevel;
			if (!moduleOn)
				irqFlag <= pcr_pkg::REG_RESET;
			else if (hit(pcr_pkg::ADDR_IRQ_FLAG))
				irqFlag <= (wByte & pcr_pkg::MASK_IRQ)
					| {4'h0, matchRise};
			else
				irqFlag <= irqFlag | {4'h0, matchRise};
		end
	end
	// interrupt line from enabled flags
	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			irq <= 1'b0;
		else
			irq <= |(irqFlag & irqEnable);
	end
	// ==========================================
	// reload arming; a software write wins over the clear
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			loadCtrl <= pcr_pkg::REG_RESET;
		end else if (hit(pcr_pkg::ADDR_LOAD_CTRL)) begin
			loadCtrl <= wByte & pcr_pkg::MASK_LOAD;
		end else if (doLoad) begin
			loadCtrl[pcr_pkg::LOAD_ARMED_BIT] <= 1'b0;
		end
	end
	// catch the chosen sibling trigger while armed
	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			trigSeen <= 1'b0;
		else if (!loadArmed || doLoad)
			trigSeen <= 1'b0;
		else if (loadOnTrig && reloadTrigIn[loadSrc])
			trigSeen <= 1'b1;
	end
	// transfer every pending count at one load
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			leadCount <= 16'h0000;
			dutyHigh <= 8'h00;
			reloadEvent <= 1'b0;
		end else begin
			reloadEvent <= doLoad;
			if (doLoad) begin
				leadCount <= {leadHigh, leadLow};
				dutyHigh <= dutyHighPend;
			end
		end
	end
	// ==========================================
	// clock source choice, reserved code gives no tick
	always_comb begin
		unique case (pcr_pkg::pcr_clk_src_t'(
			clkCtrl[pcr_pkg::CLK_SRC_LSB +: 2]))
			pcr_pkg::CS_SYSTEM: srcTick = 1'b1;
			pcr_pkg::CS_FAST_OSC: srcTick = fastOscTick;
			pcr_pkg::CS_SLOW_OSC: srcTick = slowOscTick;
			pcr_pkg::CS_RESERVED: srcTick = 1'b0;
		endcase
	end
	// prescaler: one pwm tick every two-to-the-code ticks
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			divCnt <= 7'h00;
			pwmTick <= 1'b0;
		end else if (srcTick) begin
			if (divCnt >= divLast(
				clkCtrl[pcr_pkg::CLK_DIV_LSB +: 3])) begin
				divCnt <= 7'h00;
				pwmTick <= 1'b1;
			end else begin
				divCnt <= divCnt + 7'h01;
				pwmTick <= 1'b0;
			end
		end else begin
			pwmTick <= 1'b0;
		end
	end
	// ==========================================
	// sync selection and run configuration
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			syncStart <= 1'b0;
			cfg <= '0;
		end else begin
			syncStart <= syncMatchIn[
				syncCtrl[pcr_pkg::SYNC_SRC_LSB +: 2]]
				&& (syncCtrl[pcr_pkg::SYNC_MODE_LSB +: 2]
				!= pcr_pkg::SM_INDEPENDENT);
			cfg.syncMode <= pcr_pkg::pcr_sync_mode_t'(
				syncCtrl[pcr_pkg::SYNC_MODE_LSB +: 2]);
			cfg.outMode <= pcr_pkg::pcr_out_mode_t'(
				chanCtrl[pcr_pkg::CHAN_MODE_LSB +: 2]);
			cfg.syncOnDown <= syncCtrl[pcr_pkg::CENTER_DIR_BIT]
				&& (chanCtrl[pcr_pkg::CHAN_MODE_LSB +: 2]
				== pcr_pkg::OM_CENTER);
			cfg.moduleOn <= moduleOn;
		end
	end
endmodule

/* File: tb/pcr_far_model.sv */
module pcr_far_model (
	input wire logic sys_clk, // clock
	input wire logic rst_n, // sync reset, low
	input wire logic [11:0] req, // sync, trigger, match asks
	output logic [3:0] matchLevel, // match levels
	output logic periodEnd, // period end pulse
	output logic fastOscTick, // fast osc tick
	output logic slowOscTick, // slow osc tick
	output logic [3:0] reloadTrigIn, // sibling loads
	output logic [3:0] syncMatchIn // sibling syncs
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt; // free running cycle count
	// ==========
	// counter side and siblings, all registered
	always_ff @(posedge sys_clk) begin
		cnt <= rst_n ? cnt + 1 : 0;
		periodEnd <= rst_n && cnt % 16 == 15;
		fastOscTick <= rst_n && cnt % 3 == 0;
		slowOscTick <= rst_n && cnt % 5 == 0;
		{syncMatchIn, reloadTrigIn, matchLevel} <= rst_n ? req : 12'h0;
	end
endmodule

/* File: tb/pcr_pwm_checker.sv */
module pcr_pwm_checker (
	input wire logic sys_clk, // clock
	input wire logic rst_n, // sync reset, low
	input wire logic awready, // write address ready
	input wire logic wready, // write data ready
	input wire logic bvalid, // write answer valid
	input wire logic arready, // read address ready
	input wire logic rvalid, // read data valid
	input wire logic rready, // read data ready
	input wire logic [31:0] rdata, // read data
	input wire logic periodEnd, // period end pulse
	input wire logic [3:0] syncMatchIn, // sibling syncs
	input wire logic syncStart, // selected sync
	input wire logic reloadEvent, // load pulse
	input wire logic [15:0] leadCount, // working lead
	input wire logic [7:0] dutyHigh // working duty high
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	// ==========
	// bus answers
	sequence readyBack;
		awready && wready;
	endsequence
	busy_refuse_a: assert property (bvalid |-> !awready && !wready)
		else $error("write ready during answer");
	ready_back_a: assert property ($fell(bvalid) |-> readyBack)
		else $error("write ready not back");
	read_refuse_a: assert property (rvalid |-> !arready)
		else $error("read ready during answer");
	read_once_a: assert property (rvalid && rready |=> !rvalid)
		else $error("read answer held too long");
	read_upper_a: assert property (rvalid |-> rdata[31:8] == 24'h0)
		else $error("upper read bits set");
	// ==========
	// loads and sync
	reload_end_a: assert property (
		reloadEvent |-> $past(periodEnd)) else $error("load off period end");
	lead_load_a: assert property (
		$changed(leadCount) |-> reloadEvent) else $error("lead moved alone");
	duty_load_a: assert property (
		$changed(dutyHigh) |-> reloadEvent) else $error("duty moved alone");
	sync_cause_a: assert property (
		syncStart |-> $past(syncMatchIn) != 4'h0) else $error("sync uncaused");
endmodule
bind pcr_pwm_regs pcr_pwm_checker chk_i (.sys_clk, .rst_n, .awready,
	.wready, .bvalid, .arready, .rvalid, .rready, .rdata, .periodEnd,
	.syncMatchIn, .syncStart, .reloadEvent, .leadCount, .dutyHigh);

/* File: tb/tb_top.sv */
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 0, rst_n = 0, awvalid = 0, wvalid = 0, arvalid = 0;
	logic [7:0] awaddr = 0, araddr = 0, dutyHigh, d;
	logic [31:0] wdata = 0, rdata;
	logic [11:0] req = 0; // far side asks
	logic [3:0] wstrb = 4'hf; // write byte strobes
	logic awready, wready, bvalid, arready, rvalid, irq, pwmTick;
	logic periodEnd, fastOscTick, slowOscTick, reloadEvent, syncStart;
	logic [1:0] bresp, rresp, resp;
	logic [3:0] matchLevel, reloadTrigIn, syncMatchIn;
	logic [15:0] leadCount;
	pcr_pkg::pcr_cfg_t cfg;
	int failures = 0, tests_run = 0, loads = 0, syncs = 0, g, n;
	// rows: address, written byte, byte read back
	logic [23:0] rows [8] = '{24'h00ff0f, 24'h08ff73, 24'h0c4343,
		24'h10ff73, 24'h14a5a5, 24'h183c3c, 24'h1c5a5a, 24'h20ff8c};
	always #5 sys_clk = ~sys_clk;
	// event counters
	always @(posedge sys_clk) begin
		loads <= loads + int'(reloadEvent);
		syncs <= syncs + int'(syncStart);
	end
	pcr_pwm_regs dut (.sys_clk, .rst_n, .awvalid, .awready, .awaddr,
		.wvalid, .wready, .wdata, .wstrb, .bvalid, .bready(1'b1),
		.bresp, .arvalid, .arready, .araddr, .rvalid, .rready(1'b1), .rdata,
		.rresp, .matchLevel, .periodEnd, .fastOscTick, .slowOscTick,
		.reloadTrigIn, .syncMatchIn, .irq, .pwmTick, .reloadEvent,
		.syncStart, .leadCount, .dutyHigh, .cfg);
	pcr_far_model far (.sys_clk, .rst_n, .req, .matchLevel, .periodEnd,
		.fastOscTick, .slowOscTick, .reloadTrigIn, .syncMatchIn);
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t seen=%h want=%h", $time, got, exp);
		end
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// write one register, hold each channel until taken
	task wr(input logic [7:0] a, input logic [7:0] v);
		awvalid <= 1;
		awaddr <= a;
		wvalid <= 1;
		wdata <= {24'h0, v};
		do begin
			@(posedge sys_clk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
		end while (!bvalid); // only the watchdog ends a hung wait
		resp = bresp;
	endtask
	task rd(input logic [7:0] a);
		arvalid <= 1;
		araddr <= a;
		do begin
			@(posedge sys_clk);
			if (arready) arvalid <= 0;
		end while (!rvalid); // only the watchdog ends a hung wait
		d = rdata[7:0];
		resp = rresp;
	endtask
	task kick(input logic [11:0] v);
		req <= v;
		@(posedge sys_clk);
		req <= 0;
		repeat (4) @(posedge sys_clk);
	endtask
	// wait until loads moves away from n, bounded
	task wait_load;
		g = 0;
		while (loads == n && g < 40) begin
			@(posedge sys_clk);
			g++;
		end
		@(posedge sys_clk);
	endtask
	// cycles between two divided ticks
	task gap;
		n = 0;
		while (!pwmTick && n < 600) begin
			@(posedge sys_clk);
			n++;
		end
		@(posedge sys_clk);
		g = 1;
		while (!pwmTick && g < 600) begin
			@(posedge sys_clk);
			g++;
		end
	endtask
	initial begin
		#400us;
		failures++;
		end_sim;
	end
	initial begin
		int s;
		repeat (5) @(posedge sys_clk);
		rst_n <= 1;
		@(posedge sys_clk);
		for (int i = 0; i < 9; i++) begin
			rd(8'(i * 4));
			chk(d, 0);
		end
		$display("done: reset values");
		foreach (rows[i]) begin
			wr(rows[i][23:16], rows[i][15:8]);
			rd(rows[i][23:16]);
			chk(d, rows[i][7:0]);
		end
		chk(leadCount, 0);
		chk(cfg, 6'h3f);
		wr(8'h20, 8'h88);
		repeat (2) @(posedge sys_clk);
		chk(cfg, 6'h35);
		rd(8'h24);
		chk({d, resp}, {8'h0, pcr_pkg::RESP_SLVERR});
		wr(8'h28, 8'h01);
		chk(resp, pcr_pkg::RESP_SLVERR);
		$display("done: register table");
		for (int i = 0; i < 4; i++) begin
			wr(8'h00, 8'h00);
			kick(12'(1 << i));
			chk(irq, 0);
			rd(8'h04);
			chk(d, 8'(1 << i));
			wr(8'h00, 8'(1 << i));
			repeat (2) @(posedge sys_clk);
			chk(irq, 1);
			wr(8'h04, 8'h00);
			repeat (2) @(posedge sys_clk);
			chk(irq, 0);
		end
		req <= 12'h00f;
		repeat (3) @(posedge sys_clk);
		wr(8'h04, 8'h00);
		rd(8'h04);
		chk(d, 0);
		wr(8'h20, 8'h00);
		wr(8'h04, 8'h0f);
		req <= 0;
		repeat (2) @(posedge sys_clk);
		kick(12'h00f);
		rd(8'h04);
		chk(d, 0);
		wr(8'h20, 8'h80);
		$display("done: flags");
		wr(8'h14, 8'h12);
		wr(8'h18, 8'h34);
		wr(8'h1c, 8'h56);
		n = loads;
		wr(8'h0c, 8'h80);
		wait_load;
		chk({leadCount, dutyHigh}, 24'h123456);
		rd(8'h0c);
		chk(d, 0);
		do @(posedge sys_clk); while (!periodEnd);
		n = loads;
		wr(8'h0c, 8'h80);
		wr(8'h0c, 8'h00);
		wait_load;
		chk(loads, n);
		wr(8'h18, 8'h77);
		n = loads;
		wr(8'h0c, 8'h83);
		wait_load;
		chk(leadCount, 16'h1277);
		for (int k = 1; k < 4; k++) begin
			wr(8'h18, 8'(k));
			wr(8'h0c, 8'(8'hc0 | k));
			n = loads;
			kick(12'((15 ^ (1 << k)) << 4));
			wait_load;
			chk(loads, n);
			kick(12'(16 << k));
			wait_load;
			chk(leadCount[7:0], k);
			rd(8'h0c);
			chk(d, 8'(8'h40 | k));
		end
		wstrb <= 4'he;
		wr(8'h14, 8'hee);
		chk(resp, pcr_pkg::RESP_OKAY);
		wstrb <= 4'hf;
		rd(8'h14);
		chk(d, 8'h12);
		$display("done: reload");
		for (int c = 0; c < 8; c++) begin
			wr(8'h08, 8'(c << 4));
			gap;
			gap;
			chk(g, 1 << c);
		end
		wr(8'h08, 8'h11);
		gap;
		gap;
		chk(g, 6);
		wr(8'h08, 8'h02);
		gap;
		gap;
		chk(g, 5);
		wr(8'h08, 8'h03);
		gap;
		chk(g, 600);
		$display("done: prescaler");
		for (int m = 0; m < 4; m++) begin
			s = m % 3 + 1;
			wr(8'h10, 8'((m << 5) | s));
			repeat (2) @(posedge sys_clk);
			chk(cfg.syncMode, m);
			n = syncs;
			kick(12'((15 ^ (1 << s)) << 8));
			chk(syncs, n);
			kick(12'(256 << s));
			chk(syncs - n, m != 0);
		end
		$display("done: sync");
		end_sim;
	end
endmodule
